// ### hw/unb_pkg.sv
package unb_pkg;
  // sixteen samples per bit, counter wraps at 15
  localparam logic [3:0] UNB_OVS_LAST = 4'hf;
  // majority samples at the bit centre
  localparam logic [3:0] UNB_SMP_A    = 4'h7;
  localparam logic [3:0] UNB_SMP_B    = 4'h8;
  localparam logic [3:0] UNB_SMP_C    = 4'h9;
  // frame positions: start, data 1..8, ninth 9, stop 10
  localparam logic [3:0] UNB_BIT_START = 4'h0;
  localparam logic [3:0] UNB_BIT_NINTH = 4'h9;
  localparam logic [3:0] UNB_BIT_STOP  = 4'ha;
  // last prescaler count (cpu clocks per tick less one) of the sixteen-times clock in mode 2
  localparam logic [2:0] UNB_M2_DIV_SLOW = 3'h3; // clk/64 per bit -> /4 per tick
  localparam logic [2:0] UNB_M2_DIV_FAST = 3'h1; // clk/32 per bit -> /2 per tick

  // word handed from the receiver into the buffer
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } unb_word_t;
endpackage

// ### hw/unb_buf2.sv
`timescale 1ns/1ns
// two-entry flop buffer with valid/ready on both sides
module unb_buf2 (
  // clock and reset
  input  wire logic               clock_in,
  input  wire logic               sys_rst_in,
  // filling side
  input  wire logic               in_valid_in,
  output      logic               in_ready_out,
  input  wire unb_pkg::unb_word_t in_word_in,
  // draining side
  output      logic               out_valid_out,
  input  wire logic               out_ready_in,
  output      unb_pkg::unb_word_t out_word_out
);
  import unb_pkg::*;

  unb_word_t  mem_r [2];
  logic       wr_r;
  logic       rd_r;
  logic [1:0] cnt_r;
  logic       push;
  logic       pop;

  // handshakes
  assign in_ready_out  = (cnt_r != 2'h2);
  assign out_valid_out = (cnt_r != 2'h0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_word_out  = mem_r[rd_r];

  // storage write
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_r[wr_r] <= in_word_in;
    end
  end

  // pointers and fill count
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wr_r  <= 1'b0;
      rd_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wr_r <= ~wr_r;
      if (pop) rd_r <= ~rd_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // unb_buf2

// ### hw/unb_uart.sv
`timescale 1ns/1ns
// Summary of operation
// - receive enabled: falling edge starts frame
// - sixteen samples per bit, any rate
// - start edge resets divide-by-16 counter
// - two-of-three vote at bit centre
// - start vote high: abandon, await edge
// - accept if done clear and buffer has room, stop checked only with filtering
// - accepted: buffer, ninth bit, done set
// - rejected frame changes only the overrun flag, set when only the full buffer refused it
// - after stop centre await next edge
// - eleven bits: start, 8 lsb-first, ninth, stop
// - mode 3 same frame, timer rate
// - filtering only modes 2/3 with enable
// - filtering: only ninth=1 raises done
// - no hardware address compare
// - transmit ninth from control, after rollover
// - tx done set as stop driven
// - mode 2 rate clk/64 or clk/32
// - timer overflow clock divided by 16
module unb_uart (
  // clock and reset
  input  wire logic               clock_in,
  input  wire logic               sys_rst_in,
  // serial line
  input  wire logic               rxd_in,
  output      logic               txd_out,
  // control bits
  input  wire logic               mode3_sel_in,
  input  wire logic               rx_enable_in,
  input  wire logic               multiproc_enable_in,
  input  wire logic               baud_double_in,
  input  wire logic               timer_ovf_in,
  input  wire logic               tx_ninth_bit_in,
  // software flag clears
  input  wire logic               rx_done_clr_in,
  input  wire logic               tx_done_clr_in,
  // transmit write
  input  wire logic               tx_write_in,
  input  wire logic [7:0]         tx_data_in,
  output      logic               tx_busy_out,
  // receive buffer drain
  input  wire logic               rx_read_in,
  output      unb_pkg::unb_word_t serial_buffer_out,
  output      logic               rx_ninth_bit_out,
  output      logic               rx_done_flag_out,
  output      logic               tx_done_flag_out,
  output      logic               rx_overrun_out
);
  import unb_pkg::*;

  // receiver only needs to know whether a frame is in flight;
  // the bit position inside the frame is kept in its own counter
  typedef enum {UNB_RX_IDLE, UNB_RX_BITS} unb_rx_st_t;
  // transmitter waits for a rollover so bit edges stay on the shared grid
  typedef enum {UNB_TX_IDLE, UNB_TX_WAIT, UNB_TX_SHIFT} unb_tx_st_t;

  // rate generation
  logic [2:0]  pre_r;
  logic        tick;
  logic [3:0]  txdiv_r;

  // receive timing and sampling
  logic        rxd_d_r;
  unb_rx_st_t  rx_st_r;
  logic [3:0]  rx_ph_r;
  logic [3:0]  rx_bit_r;
  logic [2:0]  smp_r;
  logic [8:0]  rx_sh_r;

  // frame acceptance
  logic        vote;
  logic        accept;
  logic        stop_ok;

  // receive buffering towards the core
  logic        buf_ready;
  logic        buf_valid;
  unb_word_t   buf_word;
  unb_word_t   buf_head;
  unb_word_t   held_r;
  logic        held_v_r;

  // receive flags
  logic        rx_done_r;
  logic        rx_ninth_r;
  logic        overrun_r;

  // transmit path
  unb_tx_st_t  tx_st_r;
  logic [10:0] tx_sh_r;
  logic [3:0]  tx_bit_r;
  logic        txd_r;
  logic        tx_done_r;
  logic        tx_roll;

  // strobe at the third centre sample of every bit
  logic        fin_bit;

  // sixteen-times tick: prescaled cpu clock in mode 2, timer overflow in mode 3
  // mode 2 rate
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || tick) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end
  assign tick = mode3_sel_in ? timer_ovf_in
              : (pre_r == (baud_double_in ? UNB_M2_DIV_FAST : UNB_M2_DIV_SLOW));

  // free-running divide-by-16 for the transmitter
  // the receiver keeps its own phase so a start edge can realign it
  // without disturbing a frame going out at the same time
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      txdiv_r <= 4'h0;
    end else if (tick) begin
      txdiv_r <= txdiv_r + 4'h1;
    end
  end
  assign tx_roll = tick && (txdiv_r == UNB_OVS_LAST);

  // line history for edge detection, sampled on each tick
  // sixteen samples per bit
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rxd_d_r <= 1'b1;
    end else if (tick) begin
      rxd_d_r <= rxd_in;
    end
  end

  // majority of the three centre samples, including the current one
  // two-of-three vote
  assign vote = (smp_r[1] & smp_r[0]) | (smp_r[1] & rxd_in) | (smp_r[0] & rxd_in);
  assign fin_bit = tick && (rx_ph_r == UNB_SMP_C);

  // centre samples collected into a small shift
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      smp_r <= 3'h0;
    end else if (tick && (rx_ph_r == UNB_SMP_A || rx_ph_r == UNB_SMP_B)) begin
      smp_r <= {smp_r[1:0], rxd_in};
    end
  end

  // stop check only matters while filtering is on; a set done flag blocks it
  // stop-centre checks
  assign stop_ok = !multiproc_enable_in || (vote && rx_sh_r[8]);
  // no address compare: any ninth=1 frame with a high stop passes
  assign accept  = !rx_done_r && stop_ok && buf_ready;

  // receive sequencer
  // the edge is only looked for on ticks, so a glitch shorter than one
  // tick may be missed entirely; a longer one that ends before the centre samples is caught by the start vote
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rx_st_r  <= UNB_RX_IDLE;
      rx_ph_r  <= 4'h0;
      rx_bit_r <= UNB_BIT_START;
      rx_sh_r  <= 9'h000;
    end else begin
      case (rx_st_r)
        UNB_RX_IDLE: begin
          if (tick && rx_enable_in && rxd_d_r && !rxd_in) begin
            rx_st_r  <= UNB_RX_BITS;
            rx_ph_r  <= 4'h1;
            rx_bit_r <= UNB_BIT_START;
          end
        end
        UNB_RX_BITS: begin
          if (tick) begin
            rx_ph_r <= rx_ph_r + 4'h1;
          end
          if (fin_bit) begin
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == UNB_BIT_START) begin
              if (vote) begin
                rx_st_r <= UNB_RX_IDLE;
              end
            end else if (rx_bit_r == UNB_BIT_STOP) begin
              rx_st_r <= UNB_RX_IDLE;
            end else begin
              rx_sh_r <= {vote, rx_sh_r[8:1]};
            end
          end
        end
        default: rx_st_r <= UNB_RX_IDLE;
      endcase
    end
  end

  // frame is pushed into the buffer only when accepted at stop centre
  // rejected frame dropped
  assign buf_word.ninth = rx_sh_r[8];
  assign buf_word.data  = rx_sh_r[7:0];

  unb_buf2 u_buf (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (fin_bit && rx_st_r == UNB_RX_BITS && rx_bit_r == UNB_BIT_STOP && accept),
    .in_ready_out  (buf_ready),
    .in_word_in    (buf_word),
    .out_valid_out (buf_valid),
    .out_ready_in  (!held_v_r || rx_read_in),
    .out_word_out  (buf_head)
  );

  // visible serial buffer holds the head word until software reads it
  // the extra stage means the core sees the word one cycle after the
  // done flag rises; it trades that lag for room for three words during a read stall
  // load buffer
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      held_r   <= '0;
      held_v_r <= 1'b0;
    end else if (buf_valid && (!held_v_r || rx_read_in)) begin
      held_r   <= buf_head;
      held_v_r <= 1'b1;
    end else if (rx_read_in) begin
      held_v_r <= 1'b0;
    end
  end

  // ninth bit and done flag; set beats a same-cycle clear
  // ninth and done
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rx_done_r  <= 1'b0;
      rx_ninth_r <= 1'b0;
    end else if (in_push_evt()) begin
      rx_done_r  <= 1'b1;
      rx_ninth_r <= rx_sh_r[8];
    end else if (rx_done_clr_in) begin
      rx_done_r  <= 1'b0;
    end
  end

  // frame lost because the stall backed up the buffer
  // a frame refused by the filter or by a set done flag is not counted
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      overrun_r <= 1'b0;
    end else if (fin_bit && rx_st_r == UNB_RX_BITS && rx_bit_r == UNB_BIT_STOP
                 && !rx_done_r && stop_ok && !buf_ready) begin
      overrun_r <= 1'b1;
    end else if (rx_done_clr_in) begin
      overrun_r <= 1'b0;
    end
  end

  // accept strobe for the flags; the buffer push repeats the same expression, so both agree
  function automatic logic in_push_evt();
    in_push_evt = fin_bit && rx_st_r == UNB_RX_BITS && rx_bit_r == UNB_BIT_STOP && accept;
  endfunction

  // transmitter: waits for rollover after write, then one bit per rollover
  // a write while busy is dropped; done rises a bit before busy falls, so software must watch tx_busy_out
  // ninth from control
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_st_r  <= UNB_TX_IDLE;
      tx_sh_r  <= 11'h7ff;
      tx_bit_r <= 4'h0;
      txd_r    <= 1'b1;
    end else begin
      case (tx_st_r)
        UNB_TX_IDLE: begin
          if (tx_write_in) begin
            tx_sh_r <= {1'b1, tx_ninth_bit_in, tx_data_in, 1'b0};
            tx_st_r <= UNB_TX_WAIT;
          end
        end
        UNB_TX_WAIT: begin
          if (tx_roll) begin
            txd_r    <= tx_sh_r[0];
            tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
            tx_bit_r <= 4'h1;
            tx_st_r  <= UNB_TX_SHIFT;
          end
        end
        UNB_TX_SHIFT: begin
          if (tx_roll) begin
            if (tx_bit_r == UNB_BIT_STOP + 4'h1) begin
              txd_r   <= 1'b1;
              tx_st_r <= UNB_TX_IDLE;
            end else begin
              txd_r    <= tx_sh_r[0];
              tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
              tx_bit_r <= tx_bit_r + 4'h1;
            end
          end
        end
        default: tx_st_r <= UNB_TX_IDLE;
      endcase
    end
  end

  // transmit done as stop bit goes out; set beats clear
  // done at stop
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_done_r <= 1'b0;
    end else if (tx_st_r == UNB_TX_SHIFT && tx_roll && tx_bit_r == UNB_BIT_STOP) begin
      tx_done_r <= 1'b1;
    end else if (tx_done_clr_in) begin
      tx_done_r <= 1'b0;
    end
  end

  // outputs
  // every level below but tx_busy_out, a decode of tx_st_r, comes straight from a register, so the core
  // never sees a combinational glitch on the flags
  assign txd_out           = txd_r;
  assign tx_busy_out       = (tx_st_r != UNB_TX_IDLE);
  assign serial_buffer_out = held_r;
  assign rx_ninth_bit_out  = rx_ninth_r;
  assign rx_done_flag_out  = rx_done_r;
  assign tx_done_flag_out  = tx_done_r;
  assign rx_overrun_out    = overrun_r;
endmodule // unb_uart

// ### test/unb_uart_asserts.sv
`timescale 1ns/1ns
// pin-level checks on the serial port; low runs on txd are timed in cycles
module unb_uart_asserts (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic txd_out,
  input wire logic mode3_sel_in,
  input wire logic baud_double_in,
  input wire logic multiproc_enable_in,
  input wire logic tx_write_in,
  input wire logic rx_done_clr_in,
  input wire logic tx_done_clr_in,
  input wire logic tx_busy_out,
  input wire logic rx_ninth_bit_out,
  input wire logic rx_done_flag_out,
  input wire logic tx_done_flag_out,
  input wire logic rx_overrun_out
);
  logic [9:0] run_r;
  logic       last_r;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // cycles spent at the present txd level, wraps harmlessly while idle
  always_ff @(posedge clock_in) begin
    last_r <= txd_out;
    if (sys_rst_in || txd_out != last_r) run_r <= 10'h1;
    else run_r <= run_r + 10'h1;
  end
  a_rx_done_holds: assert property (rx_done_flag_out && !rx_done_clr_in |=> rx_done_flag_out)
    else $error("rx done fell without a clear");
  a_tx_done_holds: assert property (tx_done_flag_out && !tx_done_clr_in |=> tx_done_flag_out)
    else $error("tx done fell without a clear");
  a_txd_idle_high: assert property (!tx_busy_out |-> txd_out)
    else $error("txd low while transmitter idle");
  a_done_on_stop: assert property ($rose(tx_done_flag_out) |-> txd_out [*8])
    else $error("tx done not raised with stop bit on line");
  a_low_run_whole: assert property ($rose(txd_out) && !$past(sys_rst_in) && !mode3_sel_in
    |-> run_r % (baud_double_in ? 32 : 64) == 0)
    else $error("txd low run not whole bits");
  a_tx_start_soon: assert property (tx_write_in && !tx_busy_out && !mode3_sel_in |-> ##[1:70] !txd_out)
    else $error("start bit late after write");
  a_mp_addr_only: assert property ($rose(rx_done_flag_out) && multiproc_enable_in
    |-> ##[0:1] rx_ninth_bit_out)
    else $error("filtered frame with ninth bit 0 raised done");
  a_ninth_on_accept: assert property ($changed(rx_ninth_bit_out) && !$past(sys_rst_in)
    |-> ##[0:1] rx_done_flag_out)
    else $error("ninth bit loaded without done");
  c_rx_word: cover property ($rose(rx_done_flag_out));
  c_tx_word: cover property ($rose(tx_done_flag_out));
  c_overrun: cover property ($rose(rx_overrun_out));
endmodule // unb_uart_asserts

bind unb_uart unb_uart_asserts i_unb_uart_asserts (.*);

// ### test/unb_node_model.sv
`timescale 1ns/1ns
// remote node on the line: sends frames on rxd, decodes frames from txd
module unb_node_model (
  // clock
  input  wire logic clock_in,
  // serial line
  input  wire logic txd_in,
  output      logic rxd_out
);
  int          bit_clks = 64;
  logic [10:0] sh, rs;
  event        got_ev;
  initial rxd_out = 1'b1;
  // eleven bits, lsb first, ninth and stop as asked
  task automatic send(input logic [7:0] d, input logic ninth, input logic stop);
    sh = {stop, ninth, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_out <= sh[i];
      repeat (bit_clks) @(posedge clock_in);
    end
    rxd_out <= 1'b1;
    repeat (bit_clks) @(posedge clock_in);
  endtask
  // short low pulse that a receiver must not take for a start bit
  task automatic glitch();
    rxd_out <= 1'b0;
    repeat (bit_clks / 4) @(posedge clock_in);
    rxd_out <= 1'b1;
    repeat (bit_clks) @(posedge clock_in);
  endtask
  // take every txd bit at its centre, away from the edges
  initial forever begin
    @(negedge txd_in);
    repeat (bit_clks / 2) @(posedge clock_in);
    for (int i = 0; i < 11; i++) begin
      rs[i] = txd_in;
      if (i < 10) repeat (bit_clks) @(posedge clock_in);
    end
    -> got_ev;
  end
endmodule // unb_node_model

// ### test/tb.sv
`timescale 1ns/1ns
// self-checking bench for the nine-bit serial port
module tb;
  import unb_pkg::*;
  logic clock_in = 1'b0, sys_rst_in = 1'b1, rxd_in, txd_out, mode3_sel_in = 1'b0, rx_enable_in = 1'b1;
  logic multiproc_enable_in = 1'b0, baud_double_in = 1'b0, timer_ovf_in = 1'b0, tx_ninth_bit_in = 1'b0;
  logic rx_done_clr_in = 1'b0, tx_done_clr_in = 1'b0, tx_write_in = 1'b0, rx_read_in = 1'b0, tx_busy_out;
  logic rx_ninth_bit_out, rx_done_flag_out, tx_done_flag_out, rx_overrun_out, clr_en = 1'b1, rd_en = 1'b1;
  logic [7:0]  tx_data_in = 8'h00;
  logic [1:0]  tdiv = 2'h0;
  logic [31:0] seed = 32'hae64;
  logic [10:0] rxq[$], txq[$];
  unb_word_t   serial_buffer_out;
  int          n_errors = 0, compares = 0;
  unb_uart i_unb_uart (.*);
  unb_node_model i_unb_node_model (.clock_in(clock_in), .txd_in(txd_out), .rxd_out(rxd_in));
  always #50 clock_in = ~clock_in;
  // timer overflow every third clock, so a mode 3 bit is 48 clocks
  always @(posedge clock_in) begin
    tdiv <= (tdiv == 2'h2) ? 2'h0 : tdiv + 2'h1;
    timer_ovf_in <= (tdiv == 2'h2);
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one frame from the far node; a word that must land is noted first
  task automatic frame(input logic ninth, input logic stop, input logic keep);
    logic [7:0] d;
    d = rnd();
    if (keep) rxq.push_back({ninth, 1'b0, ninth, d});
    i_unb_node_model.send(d, ninth, stop);
  endtask
  // one write, a second write while busy that must be ignored, then done
  task automatic tx_one();
    logic [7:0] d;
    int         k;
    d = rnd();
    txq.push_back({1'b1, d[0], d, 1'b0});
    tx_data_in <= d;
    tx_ninth_bit_in <= d[0];
    tx_write_in <= 1'b1;
    @(posedge clock_in);
    tx_data_in <= ~d;
    @(posedge clock_in);
    tx_write_in <= 1'b0;
    for (k = 0; k < 2000 && tx_done_flag_out !== 1'b1; k++) @(posedge clock_in);
    chk("tx done", 11'h1, {10'h0, tx_done_flag_out});
    if (tx_done_flag_out !== 1'b1) print_verdict();
    tx_done_clr_in <= 1'b1;
    @(posedge clock_in);
    tx_done_clr_in <= 1'b0;
    repeat (i_unb_node_model.bit_clks + 2) @(posedge clock_in);
  endtask
  // a raised done means a word: compare it, then act as the core
  initial forever begin
    @(posedge clock_in);
    if (rx_done_flag_out === 1'b1 && clr_en) begin
      @(posedge clock_in);
      if (rd_en && rxq.size() == 0) chk("unexpected word", 11'h0, 11'h7ff);
      else if (rd_en) chk("rx word", rxq.pop_front(), {rx_ninth_bit_out, 1'b0, serial_buffer_out});
      rx_read_in <= rd_en;
      rx_done_clr_in <= 1'b1;
      @(posedge clock_in);
      rx_read_in <= 1'b0;
      rx_done_clr_in <= 1'b0;
    end
  end
  // frames decoded by the far node against the words written
  initial forever begin
    @(i_unb_node_model.got_ev);
    chk("tx frame", (txq.size() > 0) ? txq.pop_front() : 11'h0, i_unb_node_model.rs);
  end
  // hang guard
  initial begin
    #9000000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      mode3_sel_in <= (m == 2);
      baud_double_in <= (m == 1);
      i_unb_node_model.bit_clks = (m == 2) ? 48 : (m == 1) ? 32 : 64;
      @(posedge clock_in);
      frame(1'b1, 1'b1, 1'b1);
      frame(1'b0, 1'b0, 1'b1);
      i_unb_node_model.glitch();
      frame(1'b0, 1'b1, 1'b1);
      tx_one();
      tx_one();
      $display("test rate %0d done", m);
    end
    multiproc_enable_in <= 1'b1;
    frame(1'b1, 1'b1, 1'b1);
    frame(1'b0, 1'b1, 1'b0);
    frame(1'b1, 1'b0, 1'b0);
    multiproc_enable_in <= 1'b0;
    frame(1'b0, 1'b1, 1'b1);
    $display("test multiprocessor done");
    clr_en <= 1'b0;
    frame(1'b0, 1'b1, 1'b1);
    frame(1'b1, 1'b1, 1'b0);
    clr_en <= 1'b1;
    rx_enable_in <= 1'b0;
    frame(1'b0, 1'b1, 1'b0);
    rx_enable_in <= 1'b1;
    $display("test refusals done");
    rd_en <= 1'b0;
    repeat (4) frame(1'b0, 1'b1, 1'b1);
    chk("overrun", 11'h1, {10'h0, rx_overrun_out});
    for (int i = 0; i < 4; i++) begin
      if (i < 2) chk("buffered word", rxq.pop_front(), {rx_ninth_bit_out, 1'b0, serial_buffer_out});
      rx_read_in <= 1'b1;
      @(posedge clock_in);
      rx_read_in <= 1'b0;
      repeat (2) @(posedge clock_in);
    end
    rxq.delete();
    rx_done_clr_in <= 1'b1;
    rd_en <= 1'b1;
    @(posedge clock_in);
    rx_done_clr_in <= 1'b0;
    @(posedge clock_in);
    chk("overrun cleared", 11'h0, {10'h0, rx_overrun_out});
    frame(1'b1, 1'b1, 1'b1);
    repeat (100) @(posedge clock_in);
    $display("test buffer done");
    print_verdict();
  end
endmodule // tb
